// ===== logic/gad_defines.svh
// Purpose: constants for the byte-to-word media adapter
// Assumes: single-word register map, word addressing
// Notes: definitions only
`ifndef GAD_DEFINES_SVH
`define GAD_DEFINES_SVH
`define GAD_CTRL_OFFSET 1'h0
`define GAD_TXOFF_BIT 0
`define GAD_TXOFF_RESET 1'h1
`define GAD_LANE_LO 0
`define GAD_LANE_HI 1
// Gigabit speed codes; the encodings are a local choice
`define GAD_MAC_SPEED_GIG 2'h0
`define GAD_PHY_SPEED_GIG 3'h0
`endif

// ===== logic/gad_pkg.sv
// Purpose: shared types for the media adapter
// Assumes: nothing
// Notes: lane packing state
package gad_pkg;
    typedef enum logic [0:0] {
        GAD_PK_LO = 1'b0,
        GAD_PK_HI = 1'b1
    } gad_pack_t;
endpackage : gad_pkg

// ===== logic/gad_sync.sv
// Purpose: three-stage level synchroniser with agreement filter
// Assumes: destination clock free running
// Notes: output changes once stages two and three agree
`timescale 1ns/1ns
module gad_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    initial
    begin
        if (W < 1)
            $error("gad_sync width must be positive");
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            q <= INIT;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                q <= s3_q;
        end
    end
endmodule : gad_sync

// ===== logic/gad_adapter.sv
// Purpose: adapts an 8-bit MAC media interface to a 16-bit PHY media interface
// Assumes: nrst synchronous to clk; PHY clocks free running
// Notes: one control register on a word-addressed zero-wait agent port
`timescale 1ns/1ns
`include "gad_defines.svh"
module gad_adapter
    import gad_pkg::*;
#(
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic derived_clock_gig,
    input wire logic derived_clock_fast,
    input wire logic derived_clock_slow,
    input wire logic pll_locked,
    input wire logic addr,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    input wire logic mac_tx_clk_o,
    output logic mac_tx_clk_i,
    output logic mac_rx_clk,
    input wire logic mac_rst_tx_n,
    input wire logic mac_rst_rx_n,
    input wire logic [DW-1:0] mac_txd,
    input wire logic mac_txen,
    input wire logic mac_txer,
    output logic mac_rxdv,
    output logic mac_rxer,
    output logic [DW-1:0] mac_rxd,
    output logic mac_col,
    output logic mac_crs,
    input wire logic [1:0] mac_speed,
    input wire logic phy_rx_clkout,
    input wire logic phy_rx_clkena,
    input wire logic phy_tx_clkout,
    input wire logic phy_tx_clkena,
    input wire logic [2*DW-1:0] wide_rx_word,
    input wire logic [1:0] wide_rx_lane_valid,
    input wire logic [1:0] wide_rx_lane_error,
    output logic [2*DW-1:0] wide_tx_word,
    output logic [1:0] wide_tx_lane_enable,
    output logic [1:0] wide_tx_lane_error,
    input wire logic [2:0] phy_speed
);
    initial
    begin
        if (DW != 8)
            $error("gad_adapter byte width must be 8");
    end

    // Register port, clk domain
    logic txoff_q;
    logic [31:0] rdata_q;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            txoff_q <= `GAD_TXOFF_RESET;
        else if (write && addr == `GAD_CTRL_OFFSET)
            txoff_q <= writedata[`GAD_TXOFF_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            rdata_q <= 32'h0;
        else if (read)
        begin
            rdata_q <= 32'h0;
            if (addr == `GAD_CTRL_OFFSET)
                rdata_q[`GAD_TXOFF_BIT] <= txoff_q;
        end
    end
    assign readdata = rdata_q;

    // Clocks to the MAC come straight from the PHY
    assign mac_tx_clk_i = phy_tx_clkout;
    assign mac_rx_clk = phy_rx_clkout;

    // Transmit domain: PHY transmit clock
    logic txoff_tx;
    logic mtx_rst_tx;
    logic tx_rst_n;
    logic [1:0] mac_speed_tx;
    logic [2:0] phy_speed_tx;
    logic gig_mode;
    // Speed pins are asynchronous; packing reads them only after sync
    gad_sync #(.W(5), .INIT(5'h0)) u_sync_speed (
        .clk(phy_tx_clkout),
        .rst_n(1'b1),
        .d({mac_speed, phy_speed}),
        .q({mac_speed_tx, phy_speed_tx})
    );
    assign gig_mode = (mac_speed_tx == `GAD_MAC_SPEED_GIG)
        || (phy_speed_tx == `GAD_PHY_SPEED_GIG);
    gad_sync #(.W(1), .INIT(1'b1)) u_sync_txoff (
        .clk(phy_tx_clkout),
        .rst_n(1'b1),
        .d(txoff_q),
        .q(txoff_tx)
    );
    gad_sync #(.W(1), .INIT(1'b0)) u_sync_mtx (
        .clk(phy_tx_clkout),
        .rst_n(1'b1),
        .d(mac_rst_tx_n),
        .q(mtx_rst_tx)
    );
    assign tx_rst_n = !txoff_tx && mtx_rst_tx;

    gad_pack_t pk_q;
    logic [DW-1:0] lo_byte_q;
    logic lo_en_q;
    logic lo_er_q;
    always_ff @(posedge phy_tx_clkout)
    begin
        if (!tx_rst_n)
        begin
            pk_q <= GAD_PK_LO;
            lo_byte_q <= '0;
            lo_en_q <= 1'b0;
            lo_er_q <= 1'b0;
            wide_tx_word <= '0;
            wide_tx_lane_enable <= 2'h0;
            wide_tx_lane_error <= 2'h0;
        end
        else if (phy_tx_clkena)
        begin
            case (pk_q)
                GAD_PK_LO:
                begin
                    lo_byte_q <= mac_txd;
                    lo_en_q <= mac_txen;
                    lo_er_q <= mac_txer;
                    pk_q <= (mac_txen || !gig_mode) ? GAD_PK_HI : GAD_PK_LO;
                end
                GAD_PK_HI:
                begin
                    wide_tx_word <= {mac_txd, lo_byte_q};
                    wide_tx_lane_enable <= {mac_txen, lo_en_q};
                    wide_tx_lane_error <= {mac_txer, lo_er_q};
                    pk_q <= GAD_PK_LO;
                end
                default:
                    pk_q <= GAD_PK_LO;
            endcase
        end
    end

    // Receive domain: PHY receive clock
    logic mrx_rst_rx;
    gad_sync #(.W(1), .INIT(1'b0)) u_sync_mrx (
        .clk(phy_rx_clkout),
        .rst_n(1'b1),
        .d(mac_rst_rx_n),
        .q(mrx_rst_rx)
    );

    logic [DW-1:0] hi_byte_q;
    logic hi_dv_q;
    logic hi_er_q;
    logic col_q;
    logic crs_q;
    always_ff @(posedge phy_rx_clkout)
    begin
        if (!mrx_rst_rx)
        begin
            mac_rxd <= '0;
            mac_rxdv <= 1'b0;
            mac_rxer <= 1'b0;
            hi_byte_q <= '0;
            hi_dv_q <= 1'b0;
            hi_er_q <= 1'b0;
        end
        else if (phy_rx_clkena)
        begin
            if (wide_rx_lane_valid[`GAD_LANE_LO])
            begin
                mac_rxd <= wide_rx_word[DW-1:0];
                mac_rxdv <= 1'b1;
                mac_rxer <= wide_rx_lane_error[`GAD_LANE_LO];
            end
            else
            begin
                mac_rxd <= '0;
                mac_rxdv <= 1'b0;
                mac_rxer <= 1'b0;
            end
            hi_byte_q <= wide_rx_word[2*DW-1:DW];
            hi_dv_q <= wide_rx_lane_valid[`GAD_LANE_HI];
            hi_er_q <= wide_rx_lane_error[`GAD_LANE_HI];
        end
        else
        begin
            mac_rxd <= hi_dv_q ? hi_byte_q : '0;
            mac_rxdv <= hi_dv_q;
            mac_rxer <= hi_dv_q && hi_er_q;
            hi_dv_q <= 1'b0;
        end
    end

    // Full duplex: no collision; carrier while either receive lane is valid
    always_ff @(posedge phy_rx_clkout)
    begin
        if (!mrx_rst_rx)
        begin
            col_q <= 1'b0;
            crs_q <= 1'b0;
        end
        else
        begin
            col_q <= 1'b0;
            crs_q <= |wide_rx_lane_valid;
        end
    end
    assign mac_col = col_q;
    assign mac_crs = crs_q;

    // Register port checks
    ctrl_reset_val_a: assert property (@(posedge clk) $rose(nrst) |-> txoff_q)
        else $error("off bit not set after reset");
    ctrl_write_a: assert property (@(posedge clk) disable iff (!nrst)
        write && !addr |=> txoff_q == $past(writedata[0]))
        else $error("control write not stored");
    write_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
        write && addr |=> $stable(txoff_q))
        else $error("write to unused offset changed control");
    read_latency_a: assert property (@(posedge clk) disable iff (!nrst)
        read && !addr |=> readdata == {31'h0, $past(txoff_q)})
        else $error("read data wrong one cycle after read");
    read_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        !read |=> $stable(readdata))
        else $error("read data changed without a read");
    read_upper_a: assert property (@(posedge clk) disable iff (!nrst)
        readdata[31:1] == 31'h0)
        else $error("reserved bits not zero");
    rdata_reset_a: assert property (@(posedge clk)
        !nrst |=> readdata == 32'h0)
        else $error("read data not cleared by reset");

    // Transmit checks, PHY transmit clock
    tx_hold_a: assert property (@(posedge phy_tx_clkout)
        !tx_rst_n |=> wide_tx_lane_enable == 2'h0 && pk_q == GAD_PK_LO)
        else $error("transmit not held while off");
    tx_pack_a: assert property (@(posedge phy_tx_clkout) disable iff (!tx_rst_n)
        phy_tx_clkena && pk_q == GAD_PK_HI
        |=> wide_tx_word[DW-1:0] == $past(lo_byte_q))
        else $error("low lane byte misplaced");
    tx_word_hi_a: assert property (@(posedge phy_tx_clkout) disable iff (!tx_rst_n)
        phy_tx_clkena && pk_q == GAD_PK_HI
        |=> wide_tx_word[2*DW-1:DW] == $past(mac_txd))
        else $error("high lane byte misplaced");
    tx_lane_en_a: assert property (@(posedge phy_tx_clkout) disable iff (!tx_rst_n)
        phy_tx_clkena && pk_q == GAD_PK_HI
        |=> wide_tx_lane_enable == {$past(mac_txen), $past(lo_en_q)})
        else $error("lane enables not paired");
    tx_lane_err_a: assert property (@(posedge phy_tx_clkout) disable iff (!tx_rst_n)
        phy_tx_clkena && pk_q == GAD_PK_HI
        |=> wide_tx_lane_error == {$past(mac_txer), $past(lo_er_q)})
        else $error("lane errors not paired");

    // Receive checks, PHY receive clock
    rx_lo_a: assert property (@(posedge phy_rx_clkout) disable iff (!mrx_rst_rx)
        phy_rx_clkena && wide_rx_lane_valid[0]
        |=> mac_rxdv && mac_rxd == $past(wide_rx_word[7:0]))
        else $error("low receive lane not forwarded");
    rx_err_lane_a: assert property (@(posedge phy_rx_clkout) disable iff (!mrx_rst_rx)
        phy_rx_clkena && wide_rx_lane_valid[0]
        |=> mac_rxer == $past(wide_rx_lane_error[0]))
        else $error("low receive lane error lost");
    rx_hi_lane_a: assert property (@(posedge phy_rx_clkout) disable iff (!mrx_rst_rx)
        phy_rx_clkena && wide_rx_lane_valid[1] ##1 !phy_rx_clkena
        |=> mac_rxdv && mac_rxd == $past(wide_rx_word[2*DW-1:DW], 2))
        else $error("high receive lane not forwarded");
    rx_hi_error_a: assert property (@(posedge phy_rx_clkout) disable iff (!mrx_rst_rx)
        phy_rx_clkena && wide_rx_lane_valid[1] ##1 !phy_rx_clkena
        |=> mac_rxer == $past(wide_rx_lane_error[1], 2))
        else $error("high receive lane error lost");
    rx_invalid_a: assert property (@(posedge phy_rx_clkout) disable iff (!mrx_rst_rx)
        phy_rx_clkena && !wide_rx_lane_valid[0] |=> !mac_rxdv)
        else $error("invalid lane forwarded");
    rx_reset_a: assert property (@(posedge phy_rx_clkout)
        !mrx_rst_rx |=> !mac_rxdv)
        else $error("receive active during MAC reset");
    crs_track_a: assert property (@(posedge phy_rx_clkout) disable iff (!mrx_rst_rx)
        mrx_rst_rx |=> mac_crs == |$past(wide_rx_lane_valid))
        else $error("carrier sense does not follow lane valid");
    carrier_reset_a: assert property (@(posedge phy_rx_clkout)
        !mrx_rst_rx |=> !mac_crs && !mac_col)
        else $error("carrier or collision active during MAC reset");
endmodule : gad_adapter

// ===== tb/gad_phy_model.sv
// Purpose: PHY-side model for the media adapter
// Assumes: link clocks free running at 80 ns
// Notes: receive enable alternates, gigabit transmit
`timescale 1ns/1ns
module gad_phy_model (
    output logic tx_clk,
    output logic rx_clk,
    output logic tx_ena,
    output logic rx_ena,
    input wire logic [15:0] word,
    input wire logic [1:0] valid,
    input wire logic [1:0] err,
    output logic [15:0] rx_word,
    output logic [1:0] rx_valid,
    output logic [1:0] rx_err
);
    assign tx_ena = 1'b1; // Gigabit: every edge carries a byte
    initial
    begin
        tx_clk = 1'b0;
        rx_clk = 1'b0;
        rx_ena = 1'b0;
        rx_word = 16'h0;
        rx_valid = 2'h0;
        rx_err = 2'h0;
        #7;
        forever
        begin
            #40 tx_clk = ~tx_clk;
            rx_clk = tx_clk;
        end
    end
    // Word only under enable, scrambled otherwise
    always @(posedge rx_clk)
    begin
        rx_ena <= ~rx_ena;
        rx_word <= rx_ena ? ~word : word;
        rx_valid <= rx_ena ? ~valid : valid;
        rx_err <= rx_ena ? ~err : err;
    end
endmodule : gad_phy_model

// ===== tb/gad_adapter_bench.sv
// Purpose: self-checking bench for the media adapter
// Assumes: PHY model supplies link clocks
// Notes: gigabit speed codes, then slower codes in t_speed
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module gad_adapter_bench;
    int error_cnt = 0;
    int total_checks = 0;
    logic clk, nrst, addr, read, write, pll_locked, txclk, rxclk, txena, rxena;
    logic tx_fwd, rx_fwd, rst_tx_n, rst_rx_n, txen, txer, rxdv, rxer, col, crs;
    logic [31:0] writedata, readdata;
    logic [7:0] txd, rxd;
    logic [1:0] mac_speed, v, e, rv, re, ten, ter;
    logic [2:0] phy_speed;
    logic [15:0] w, rw, tw;
    gad_phy_model phy (.tx_clk(txclk), .rx_clk(rxclk), .tx_ena(txena), .rx_ena(rxena),
        .word(w), .valid(v), .err(e), .rx_word(rw), .rx_valid(rv), .rx_err(re));
    gad_adapter DUT (.clk(clk), .nrst(nrst), .derived_clock_gig(clk),
        .derived_clock_fast(txclk), .derived_clock_slow(rxclk), .pll_locked(pll_locked),
        .addr(addr), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .mac_tx_clk_o(txclk), .mac_tx_clk_i(tx_fwd), .mac_rx_clk(rx_fwd),
        .mac_rst_tx_n(rst_tx_n), .mac_rst_rx_n(rst_rx_n), .mac_txd(txd), .mac_txen(txen),
        .mac_txer(txer), .mac_rxdv(rxdv), .mac_rxer(rxer), .mac_rxd(rxd), .mac_col(col),
        .mac_crs(crs), .mac_speed(mac_speed), .phy_rx_clkout(rxclk), .phy_rx_clkena(rxena),
        .phy_tx_clkout(txclk), .phy_tx_clkena(txena), .wide_rx_word(rw),
        .wide_rx_lane_valid(rv), .wide_rx_lane_error(re), .wide_tx_word(tw),
        .wide_tx_lane_enable(ten), .wide_tx_lane_error(ter), .phy_speed(phy_speed));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task results;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    task wr(input logic a, input logic [31:0] d);
        @(posedge clk);
        write <= 1'b1;
        addr <= a;
        writedata <= d;
        @(posedge clk);
        write <= 1'b0;
    endtask : wr
    task rd(input logic a, input logic [31:0] x);
        @(posedge clk);
        read <= 1'b1;
        addr <= a;
        @(posedge clk);
        read <= 1'b0;
        #1;
        `CHK(readdata, x)
    endtask : rd
    task send(input logic [7:0] a, input logic [7:0] b, input logic er);
        @(posedge txclk);
        txen <= 1'b1;
        txd <= a;
        @(posedge txclk);
        txd <= b;
        txer <= er;
        @(posedge txclk);
        txen <= 1'b0;
        txer <= 1'b0;
        txd <= ~b;
        #1;
    endtask : send
    task rx_pair(input logic [15:0] ww, input logic [1:0] vv, input logic [1:0] ee);
        w = ww;
        v = vv;
        e = ee;
        do
        begin
            @(posedge rxclk);
            #1;
        end
        while (rxena !== 1'b1);
        @(posedge rxclk);
        #1;
        `CHK({rxd, rxdv, rxer, crs, col}, {ww[7:0], vv[0], ee[0], |vv, 1'b0})
        @(posedge rxclk);
        #1;
        `CHK({rxdv, rxer}, {vv[1], vv[1] & ee[1]})
        if (vv[1])
            `CHK(rxd, ww[15:8])
    endtask : rx_pair
    task t_regs;
        rd(1'b0, 32'h1);
        rd(1'b1, 32'h0);
        wr(1'b1, 32'h0);
        rd(1'b0, 32'h1);
    endtask : t_regs
    task t_tx;
        send(8'h11, 8'h22, 1'b0);
        `CHK({tw, ten}, 18'h0)
        wr(1'b0, 32'hfffffffe);
        rd(1'b0, 32'h0);
        repeat (8) @(posedge txclk);
        send(8'h5a, 8'ha5, 1'b1);
        `CHK({tw, ten, ter}, {16'ha55a, 2'b11, 2'b10})
        `CHK({tx_fwd, rx_fwd}, {txclk, rxclk})
        @(posedge txclk);
        rst_tx_n <= 1'b0;
        repeat (8) @(posedge txclk);
        #1;
        `CHK({tw, ten}, 18'h0)
        rst_tx_n <= 1'b1;
        repeat (8) @(posedge txclk);
    endtask : t_tx
    task t_rx;
        rx_pair(16'hb2a1, 2'b11, 2'b10);
        rx_pair(16'h4c3d, 2'b01, 2'b11);
        @(posedge rxclk);
        rst_rx_n <= 1'b0;
        repeat (8) @(posedge rxclk);
        #1;
        `CHK({rxdv, rxd}, 9'h0)
        rst_rx_n <= 1'b1;
    endtask : t_rx
    task t_speed;
        wr(1'b0, 32'h1);
        mac_speed <= 2'h1; // Speed changed with transmit off
        phy_speed <= 3'h1;
        repeat (8) @(posedge txclk);
        send(8'h33, 8'h44, 1'b0);
        `CHK({tw, ten}, 18'h0)
        wr(1'b0, 32'h0);
        repeat (8) @(posedge txclk);
        txen <= 1'b1; // Slower rate completes a pair on every second edge
        txd <= 8'h77;
        repeat (3) @(posedge txclk);
        #1;
        `CHK({tw, ten, ter}, {16'h7777, 2'b11, 2'b00})
        @(posedge txclk);
        txen <= 1'b0; // Pairs go on without enable, unlike gigabit
        repeat (3) @(posedge txclk);
        #1;
        `CHK({tw, ten}, {16'h7777, 2'b00})
    endtask : t_speed
    initial
    begin
        nrst = 1'b0;
        addr = 1'b0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        pll_locked = 1'b1;
        rst_tx_n = 1'b1;
        rst_rx_n = 1'b1;
        txd = 8'h0;
        txen = 1'b0;
        txer = 1'b0;
        mac_speed = 2'h0;
        phy_speed = 3'h0;
        w = 16'h0;
        v = 2'h0;
        e = 2'h0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1; // Release on a clock edge
        repeat (8) @(posedge txclk);
        t_regs();
        t_tx();
        t_rx();
        t_speed();
        results();
    end
    initial
    begin
        #100000;
        error_cnt++;
        results();
    end
endmodule : gad_adapter_bench
